/* File: shared/lowio_pkg.sv */
// Shared constants and types for the low I/O register space
package lowio_pkg;

    // ------------------------------------------------------------
    // Address views
    // ------------------------------------------------------------
    localparam logic [7:0] LOWIO_IO_TOP = 8'h3f;
    localparam logic [7:0] LOWIO_BIT_TOP = 8'h1f;
    localparam logic [7:0] LOWIO_DATA_OFS = 8'h20;
    localparam logic [7:0] LOWIO_EXT_LO = 8'h60;

    // ------------------------------------------------------------
    // I/O register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] LOWIO_PORT_B_PIN = 6'h03;
    localparam logic [5:0] LOWIO_PORT_B_DIR = 6'h04;
    localparam logic [5:0] LOWIO_PORT_B_OUT = 6'h05;
    localparam logic [5:0] LOWIO_PORT_C_PIN = 6'h06;
    localparam logic [5:0] LOWIO_PORT_C_DIR = 6'h07;
    localparam logic [5:0] LOWIO_PORT_C_OUT = 6'h08;
    localparam logic [5:0] LOWIO_PORT_D_PIN = 6'h09;
    localparam logic [5:0] LOWIO_PORT_D_DIR = 6'h0a;
    localparam logic [5:0] LOWIO_PORT_D_OUT = 6'h0b;
    localparam logic [5:0] LOWIO_EXT_IRQ_MASK = 6'h1d;

    // ------------------------------------------------------------
    // Flag bank: slot 0 timer0, 1 timer1, 2 timer2, 3 pin change, 4 ext irq
    // ------------------------------------------------------------
    localparam int LOWIO_NUM_FLAG_REGS = 5;
    localparam logic [4:0][5:0] LOWIO_FLAG_ADDRS = {6'h1c, 6'h1b, 6'h17, 6'h16, 6'h15};
    localparam logic [4:0][7:0] LOWIO_FLAG_MASKS = {8'h03, 8'h07, 8'h07, 8'h27, 8'h07};

    // ------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LOWIO_PORT_C_MASK = 8'h7f;
    localparam logic [7:0] LOWIO_EXT_IRQ_MASK_BITS = 8'h03;
    localparam logic [7:0] LOWIO_RESET_VAL = 8'h00;

    // Access kinds issued by the core
    typedef enum logic [2:0] {
        LOWIO_OP_IO_READ = 3'b000,
        LOWIO_OP_IO_WRITE = 3'b001,
        LOWIO_OP_DATA_LOAD = 3'b010,
        LOWIO_OP_DATA_STORE = 3'b011,
        LOWIO_OP_SET_BIT = 3'b100,
        LOWIO_OP_CLEAR_BIT = 3'b101,
        LOWIO_OP_SKIP_SET = 3'b110,
        LOWIO_OP_SKIP_CLEAR = 3'b111
    } lowio_op_e;

endpackage : lowio_pkg

/* File: shared/lowio_flag_if.sv */
// Carrier between the register decoder and the flag bank
`timescale 1ns/1ps
interface lowio_flag_if;
    logic [4:0][7:0] evt;
    logic [4:0][7:0] clr;
    logic [4:0][7:0] flags;

    modport owner (input evt, input clr, output flags);
    modport user (output evt, output clr, input flags);
endinterface : lowio_flag_if

/* File: rtl/lowio_flag_bank.sv */
// Sticky event flags, cleared by writing one
`timescale 1ns/1ps
module lowio_flag_bank (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    lowio_flag_if.owner fl
);
    import lowio_pkg::*;

    typedef struct packed {
        logic [4:0][7:0] flags;
    } lowio_flag_state_s;

    lowio_flag_state_s state_reg;
    lowio_flag_state_s state_next;

    // Event set wins over a same-cycle clear, so no event is lost
    always_comb
    begin
        state_next = state_reg;
        for (int s = 0; s < LOWIO_NUM_FLAG_REGS; s++)
        begin
            state_next.flags[s] = ((state_reg.flags[s] & ~fl.clr[s]) | fl.evt[s])
                & LOWIO_FLAG_MASKS[s];
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign fl.flags = state_reg.flags;

    AST_W1C_ZERO_KEEPS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (fl.clr == '0 && fl.evt == '0) |=> $stable(fl.flags))
        else $error("flag changed with no event and no clear");

    AST_EVENT_SETS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ((fl.evt & fl.clr & LOWIO_FLAG_MASKS) != '0)
        |=> (($past(fl.evt) & $past(fl.clr) & LOWIO_FLAG_MASKS & ~fl.flags) == '0))
        else $error("flag event lost against a clear");
endmodule : lowio_flag_bank

/* File: rtl/lowio_regs.sv */
// Low I/O register space: ports, flags, masks and bit access
`timescale 1ns/1ps
module lowio_regs #(
    parameter int DATA_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire lowio_pkg::lowio_op_e req_op_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic [2:0] req_bit_i,
    output logic resp_valid_o,
    output logic [7:0] resp_rdata_o,
    output logic resp_skip_o,
    output logic resp_err_o,
    input wire logic [7:0] port_b_pins_i,
    input wire logic [7:0] port_c_pins_i,
    input wire logic [7:0] port_d_pins_i,
    output logic [7:0] port_b_output_latch_o,
    output logic [7:0] port_b_direction_o,
    output logic [7:0] port_c_output_latch_o,
    output logic [7:0] port_c_direction_o,
    output logic [7:0] port_d_output_latch_o,
    output logic [7:0] port_d_direction_o,
    output logic [7:0] ext_irq_mask_o,
    input wire logic [7:0] timer0_evt_i,
    input wire logic [7:0] timer1_evt_i,
    input wire logic [7:0] timer2_evt_i,
    input wire logic [7:0] pin_change_evt_i,
    input wire logic [7:0] ext_irq_evt_i,
    output logic [7:0] timer0_flags_o,
    output logic [7:0] timer1_flags_o,
    output logic [7:0] timer2_flags_o,
    output logic [7:0] pin_change_flags_o,
    output logic [7:0] ext_irq_flags_o
);
    import lowio_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DATA_W != 8)
    begin : g_bad_width
        $error("lowio_regs serves only an 8-bit data path");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] b_out;
        logic [7:0] b_dir;
        logic [7:0] b_pin;
        logic [7:0] c_out;
        logic [7:0] c_dir;
        logic [7:0] c_pin;
        logic [7:0] d_out;
        logic [7:0] d_dir;
        logic [7:0] d_pin;
        logic [7:0] irq_mask;
        logic resp;
        logic [7:0] rdata;
        logic skip;
        logic err;
    } lowio_state_s;

    lowio_state_s state_reg;
    lowio_state_s state_next;

    lowio_flag_if fl_if ();

    logic acc_ok;
    logic in_io;
    logic [5:0] io_idx;
    logic [7:0] cur_val;
    logic [7:0] bit_m;
    logic [7:0] wr_val;
    logic [7:0] clr_pat;
    logic is_wr;
    logic is_rd;
    logic is_skip;

    // ------------------------------------------------------------
    // Address decode for the two views
    // ------------------------------------------------------------
    // Data addresses below 0x20 and from 0x60 up belong elsewhere,
    // so they answer without error but read zero here.
    always_comb
    begin
        acc_ok = 1'b0;
        in_io = 1'b0;
        io_idx = 6'h00;
        unique case (req_op_i)
            LOWIO_OP_IO_READ, LOWIO_OP_IO_WRITE:
            begin
                acc_ok = (req_addr_i <= LOWIO_IO_TOP);
                in_io = acc_ok;
                io_idx = req_addr_i[5:0];
            end
            LOWIO_OP_DATA_LOAD, LOWIO_OP_DATA_STORE:
            begin
                acc_ok = 1'b1;
                in_io = (req_addr_i >= LOWIO_DATA_OFS) && (req_addr_i < LOWIO_EXT_LO);
                io_idx = 6'(req_addr_i - LOWIO_DATA_OFS);
            end
            LOWIO_OP_SET_BIT, LOWIO_OP_CLEAR_BIT,
            LOWIO_OP_SKIP_SET, LOWIO_OP_SKIP_CLEAR:
            begin
                acc_ok = (req_addr_i <= LOWIO_BIT_TOP);
                in_io = acc_ok;
                io_idx = req_addr_i[5:0];
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unlisted offsets fall to zero: reserved space reads empty
    always_comb
    begin
        cur_val = 8'h00;
        if (in_io)
        begin
            unique case (io_idx)
                LOWIO_PORT_B_PIN: cur_val = state_reg.b_pin;
                LOWIO_PORT_B_DIR: cur_val = state_reg.b_dir;
                LOWIO_PORT_B_OUT: cur_val = state_reg.b_out;
                LOWIO_PORT_C_PIN: cur_val = state_reg.c_pin;
                LOWIO_PORT_C_DIR: cur_val = state_reg.c_dir;
                LOWIO_PORT_C_OUT: cur_val = state_reg.c_out;
                LOWIO_PORT_D_PIN: cur_val = state_reg.d_pin;
                LOWIO_PORT_D_DIR: cur_val = state_reg.d_dir;
                LOWIO_PORT_D_OUT: cur_val = state_reg.d_out;
                LOWIO_EXT_IRQ_MASK: cur_val = state_reg.irq_mask;
                default:
                begin
                    for (int s = 0; s < LOWIO_NUM_FLAG_REGS; s++)
                    begin
                        if (io_idx == LOWIO_FLAG_ADDRS[s])
                            cur_val = fl_if.flags[s];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write value forming
    // ------------------------------------------------------------
    // Bit ops read-modify-write plain registers, but on flags set-bit
    // presents only the addressed bit and clear-bit none, so siblings are never cleared.
    always_comb
    begin
        is_rd = req_valid_i && in_io &&
            (req_op_i == LOWIO_OP_IO_READ || req_op_i == LOWIO_OP_DATA_LOAD);
        is_wr = req_valid_i && in_io &&
            (req_op_i == LOWIO_OP_IO_WRITE || req_op_i == LOWIO_OP_DATA_STORE ||
             req_op_i == LOWIO_OP_SET_BIT || req_op_i == LOWIO_OP_CLEAR_BIT);
        is_skip = req_valid_i && acc_ok &&
            (req_op_i == LOWIO_OP_SKIP_SET || req_op_i == LOWIO_OP_SKIP_CLEAR);
        bit_m = 8'(8'h01 << req_bit_i);
        if (req_op_i == LOWIO_OP_SET_BIT)
        begin
            wr_val = cur_val | bit_m;
            clr_pat = bit_m;
        end
        else if (req_op_i == LOWIO_OP_CLEAR_BIT)
        begin
            wr_val = cur_val & ~bit_m;
            clr_pat = 8'h00;
        end
        else
        begin
            wr_val = req_wdata_i;
            clr_pat = req_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Pins are sampled every cycle; writes to pin inputs and to
    // reserved offsets fall through untouched.
    always_comb
    begin
        state_next = state_reg;
        state_next.b_pin = port_b_pins_i;
        state_next.c_pin = port_c_pins_i & LOWIO_PORT_C_MASK;
        state_next.d_pin = port_d_pins_i;
        fl_if.clr = '0;
        if (is_wr)
        begin
            unique case (io_idx)
                LOWIO_PORT_B_DIR: state_next.b_dir = wr_val;
                LOWIO_PORT_B_OUT: state_next.b_out = wr_val;
                LOWIO_PORT_C_DIR: state_next.c_dir = wr_val & LOWIO_PORT_C_MASK;
                LOWIO_PORT_C_OUT: state_next.c_out = wr_val & LOWIO_PORT_C_MASK;
                LOWIO_PORT_D_DIR: state_next.d_dir = wr_val;
                LOWIO_PORT_D_OUT: state_next.d_out = wr_val;
                LOWIO_EXT_IRQ_MASK:
                    state_next.irq_mask = wr_val & LOWIO_EXT_IRQ_MASK_BITS;
                default:
                begin
                    for (int s = 0; s < LOWIO_NUM_FLAG_REGS; s++)
                    begin
                        if (io_idx == LOWIO_FLAG_ADDRS[s])
                            fl_if.clr[s] = clr_pat;
                    end
                end
            endcase
        end
        // Response fields, one cycle after the request
        state_next.resp = req_valid_i;
        state_next.err = req_valid_i && !acc_ok;
        state_next.rdata = is_rd ? cur_val : 8'h00;
        state_next.skip = is_skip &&
            (cur_val[req_bit_i] == (req_op_i == LOWIO_OP_SKIP_SET));
    end

    // Event inputs feed the flag bank, masked there to implemented bits
    assign fl_if.evt = {ext_irq_evt_i, pin_change_evt_i, timer2_evt_i,
                        timer1_evt_i, timer0_evt_i};

    // ------------------------------------------------------------
    // Flag bank
    // ------------------------------------------------------------
    lowio_flag_bank u_flag_bank (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .fl(fl_if.owner)
    );

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // Outputs straight from flops
    assign resp_valid_o = state_reg.resp;
    assign resp_rdata_o = state_reg.rdata;
    assign resp_skip_o = state_reg.skip;
    assign resp_err_o = state_reg.err;
    assign port_b_output_latch_o = state_reg.b_out;
    assign port_b_direction_o = state_reg.b_dir;
    assign port_c_output_latch_o = state_reg.c_out;
    assign port_c_direction_o = state_reg.c_dir;
    assign port_d_output_latch_o = state_reg.d_out;
    assign port_d_direction_o = state_reg.d_dir;
    assign ext_irq_mask_o = state_reg.irq_mask;
    assign timer0_flags_o = fl_if.flags[0];
    assign timer1_flags_o = fl_if.flags[1];
    assign timer2_flags_o = fl_if.flags[2];
    assign pin_change_flags_o = fl_if.flags[3];
    assign ext_irq_flags_o = fl_if.flags[4];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_bit_op_high;
        req_valid_i && (req_op_i == LOWIO_OP_SET_BIT || req_op_i == LOWIO_OP_CLEAR_BIT)
            && (req_addr_i > LOWIO_BIT_TOP);
    endsequence

    sequence seq_store_b_data;
        req_valid_i && req_op_i == LOWIO_OP_DATA_STORE && req_addr_i == 8'h25;
    endsequence

    AST_BIT_RANGE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        seq_bit_op_high |=> resp_err_o && $stable(port_b_output_latch_o))
        else $error("bit op above 0x1f not refused");

    AST_SKIP_TEST: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (req_valid_i && req_op_i == LOWIO_OP_SKIP_SET && req_addr_i == 8'h05)
        |=> resp_skip_o == |($past(port_b_output_latch_o) & $past(bit_m)))
        else $error("skip result does not match tested bit");

    AST_SET_BIT_KEEPS_SIBLINGS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (req_valid_i && req_op_i == LOWIO_OP_SET_BIT && req_addr_i == 8'h16)
        |=> (($past(timer1_flags_o) & ~$past(bit_m)) & ~timer1_flags_o) == 8'h00)
        else $error("bit op cleared a sibling flag");

    AST_IO_LIMIT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (req_valid_i && req_op_i == LOWIO_OP_IO_READ && req_addr_i > LOWIO_IO_TOP)
        |=> resp_err_o && resp_rdata_o == 8'h00)
        else $error("I/O access above 0x3f not refused");

    AST_DATA_VIEW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        seq_store_b_data ##1 (resp_valid_o && !resp_err_o)
        |-> port_b_output_latch_o == $past(req_wdata_i))
        else $error("data store at 0x25 missed the port b latch");

    AST_EXT_DATA: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (req_valid_i && req_op_i == LOWIO_OP_DATA_LOAD && req_addr_i >= LOWIO_EXT_LO)
        |=> !resp_err_o && resp_rdata_o == 8'h00)
        else $error("extended data load handled wrongly");

    AST_PORT_C_OUTPUT_LATCH_B7: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !port_c_output_latch_o[7] && !port_c_direction_o[7])
        else $error("port c bit 7 is set");

    AST_RSVD_READ: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (req_valid_i && req_op_i == LOWIO_OP_IO_READ && req_addr_i == 8'h0c)
        |=> resp_valid_o && resp_rdata_o == 8'h00)
        else $error("reserved offset read nonzero");

    AST_MASK_BITS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ext_irq_mask_o & ~LOWIO_EXT_IRQ_MASK_BITS) == 8'h00)
        else $error("reserved mask bit set");
endmodule : lowio_regs

/* File: bench/lowio_core_model.sv */
// Behavioural core model issuing accesses into the low I/O register space
`timescale 1ns/1ps
module lowio_core_model (
    input wire logic clk_sys_i,
    output lowio_pkg::lowio_op_e req_op_o,
    output logic req_valid_o,
    output logic [7:0] req_addr_o,
    output logic [7:0] req_wdata_o,
    output logic [2:0] req_bit_o,
    input wire logic resp_valid_i,
    input wire logic [7:0] resp_rdata_i,
    input wire logic resp_skip_i,
    input wire logic resp_err_i
);
    import lowio_pkg::*;

    // Well-behaved software by default; the bench clears this to misbehave on purpose
    bit strict = 1'b1;

    initial
    begin
        req_valid_o = 1'b0;
        req_op_o = LOWIO_OP_IO_READ;
        req_addr_o = 8'h00;
        req_wdata_o = 8'h00;
        req_bit_o = 3'h0;
    end

    // ------------------------------------------------------------
    // Implemented bits per I/O address, zero means reserved
    // ------------------------------------------------------------
    function automatic logic [7:0] impl_bits(input logic [7:0] a);
        case (a)
            8'h03, 8'h04, 8'h05, 8'h09, 8'h0a, 8'h0b: return 8'hff;
            8'h06, 8'h07, 8'h08: return 8'h7f;
            8'h15, 8'h17, 8'h1b: return 8'h07;
            8'h16: return 8'h27;
            8'h1c, 8'h1d: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : impl_bits

    // ------------------------------------------------------------
    // One access: one-cycle request pulse, answer one cycle later
    // ------------------------------------------------------------
    task automatic access(input lowio_op_e op, input logic [7:0] addr, input logic [7:0] wdata,
        input logic [2:0] bit_no, output logic [7:0] rdata, output logic skip,
        output logic err, output logic vld);
        logic [7:0] ia;
        logic [7:0] wd;
        logic wr;
        ia = (op == LOWIO_OP_DATA_STORE) ? addr - 8'h20 : addr;
        wr = (op == LOWIO_OP_IO_WRITE) || (op == LOWIO_OP_DATA_STORE);
        wd = (strict && wr) ? (wdata & impl_bits(ia)) : wdata;
        rdata = 8'h00;
        skip = 1'b0;
        err = 1'b0;
        vld = 1'b1;
        // In strict mode, writes to reserved places are simply never issued
        if (strict && wr && impl_bits(ia) == 8'h00)
        begin
            return;
        end
        @(posedge clk_sys_i);
        req_valid_o <= 1'b1;
        req_op_o <= op;
        req_addr_o <= addr;
        req_wdata_o <= wd;
        req_bit_o <= bit_no;
        @(posedge clk_sys_i);
        req_valid_o <= 1'b0;
        // Response stands for one cycle only, taken once the edge has settled
        #1;
        rdata = resp_rdata_i;
        skip = resp_skip_i;
        err = resp_err_i;
        vld = resp_valid_i;
    endtask : access
endmodule : lowio_core_model

/* File: bench/test_low_io_register_space.sv */
// Self-checking testbench for the low I/O register space
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        cmp_count++; \
        if ((a) !== (e)) \
        begin \
            n_mismatch++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); \
        end \
    end
module test_low_io_register_space;
    import lowio_pkg::*;

    typedef struct {
        lowio_op_e op;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [2:0] bit_no;
        logic [7:0] rdata;
        logic skip;
        logic err;
    } lowio_row_s;

    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] pb_pins = 8'h3c, pc_pins = 8'hff, pd_pins = 8'h96;
    logic [7:0] t0_evt = 8'h00, t1_evt = 8'h00, t2_evt = 8'h00, pc_evt = 8'h00, ei_evt = 8'h00;
    lowio_op_e req_op;
    logic req_valid, resp_valid, resp_skip, resp_err;
    logic [7:0] req_addr, req_wdata, resp_rdata;
    logic [2:0] req_bit;
    logic [7:0] pb_out, pb_dir, pc_out, pc_dir, pd_out, pd_dir, ei_mask;
    logic [7:0] t0_fl, t1_fl, t2_fl, pc_fl, ei_fl;
    logic [7:0] rd;
    logic sk, er, vl;
    int n_mismatch = 0;
    int cmp_count = 0;

    // ------------------------------------------------------------
    // Ordinary cases, state carries from row to row
    // ------------------------------------------------------------
    lowio_row_s rows [22] = '{
        '{LOWIO_OP_DATA_STORE, 8'h25, 8'ha5, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_IO_READ, 8'h05, 8'h00, 3'h0, 8'ha5, 1'b0, 1'b0},
        '{LOWIO_OP_SET_BIT, 8'h05, 8'h00, 3'h1, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_CLEAR_BIT, 8'h05, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_IO_READ, 8'h05, 8'h00, 3'h0, 8'ha6, 1'b0, 1'b0},
        '{LOWIO_OP_SKIP_SET, 8'h05, 8'h00, 3'h1, 8'h00, 1'b1, 1'b0},
        '{LOWIO_OP_SKIP_CLEAR, 8'h05, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0},
        '{LOWIO_OP_SKIP_SET, 8'h05, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_IO_WRITE, 8'h04, 8'h3c, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_DATA_LOAD, 8'h24, 8'h00, 3'h0, 8'h3c, 1'b0, 1'b0},
        '{LOWIO_OP_IO_WRITE, 8'h0b, 8'h5a, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_IO_WRITE, 8'h0a, 8'hc3, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_DATA_LOAD, 8'h2b, 8'h00, 3'h0, 8'h5a, 1'b0, 1'b0},
        '{LOWIO_OP_IO_READ, 8'h09, 8'h00, 3'h0, 8'h96, 1'b0, 1'b0},
        '{LOWIO_OP_IO_READ, 8'h06, 8'h00, 3'h0, 8'h7f, 1'b0, 1'b0},
        '{LOWIO_OP_IO_WRITE, 8'h03, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_IO_READ, 8'h03, 8'h00, 3'h0, 8'h3c, 1'b0, 1'b0},
        '{LOWIO_OP_IO_WRITE, 8'h1d, 8'h03, 3'h0, 8'h00, 1'b0, 1'b0},
        '{LOWIO_OP_SET_BIT, 8'h20, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1},
        '{LOWIO_OP_SKIP_SET, 8'h20, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1},
        '{LOWIO_OP_IO_READ, 8'h40, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1},
        '{LOWIO_OP_DATA_LOAD, 8'h60, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0}
    };

    // Clock at 25 MHz
    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    lowio_core_model core_u (.clk_sys_i(clk_sys_i), .req_op_o(req_op), .req_valid_o(req_valid),
        .req_addr_o(req_addr), .req_wdata_o(req_wdata), .req_bit_o(req_bit),
        .resp_valid_i(resp_valid), .resp_rdata_i(resp_rdata), .resp_skip_i(resp_skip),
        .resp_err_i(resp_err));

    lowio_regs dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_valid_i(req_valid),
        .req_op_i(req_op), .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_bit_i(req_bit),
        .resp_valid_o(resp_valid), .resp_rdata_o(resp_rdata), .resp_skip_o(resp_skip),
        .resp_err_o(resp_err), .port_b_pins_i(pb_pins), .port_c_pins_i(pc_pins),
        .port_d_pins_i(pd_pins), .port_b_output_latch_o(pb_out), .port_b_direction_o(pb_dir),
        .port_c_output_latch_o(pc_out), .port_c_direction_o(pc_dir),
        .port_d_output_latch_o(pd_out), .port_d_direction_o(pd_dir), .ext_irq_mask_o(ei_mask),
        .timer0_evt_i(t0_evt), .timer1_evt_i(t1_evt), .timer2_evt_i(t2_evt),
        .pin_change_evt_i(pc_evt), .ext_irq_evt_i(ei_evt), .timer0_flags_o(t0_fl),
        .timer1_flags_o(t1_fl), .timer2_flags_o(t2_fl), .pin_change_flags_o(pc_fl),
        .ext_irq_flags_o(ei_fl));

    // Shorthand for accesses whose answer is not looked at
    task automatic acc(input lowio_op_e op, input logic [7:0] a, input logic [7:0] w,
        input logic [2:0] b);
        core_u.access(op, a, w, b, rd, sk, er, vl);
    endtask : acc

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // Watchdog: the whole run needs under a hundred cycles
    initial
    begin
        repeat (3000) @(posedge clk_sys_i);
        n_mismatch++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        foreach (rows[i])
        begin
            core_u.access(rows[i].op, rows[i].addr, rows[i].wdata, rows[i].bit_no, rd, sk, er, vl);
            `CHK(vl, 1'b1)
            `CHK(rd, rows[i].rdata)
            `CHK(sk, rows[i].skip)
            `CHK(er, rows[i].err)
        end
        `CHK({pb_out, pb_dir, pd_out, pd_dir, ei_mask}, 40'ha63c5ac303)
        $display("table cases done");
        // Every event line high for a cycle; unimplemented bits must not stick
        @(posedge clk_sys_i);
        {t0_evt, t1_evt, t2_evt, pc_evt, ei_evt} <= {5{8'hff}};
        @(posedge clk_sys_i);
        {t0_evt, t1_evt, t2_evt, pc_evt, ei_evt} <= {5{8'h00}};
        @(posedge clk_sys_i);
        #1;
        `CHK({t0_fl, t1_fl, t2_fl, pc_fl, ei_fl}, 40'h0727070703)
        acc(LOWIO_OP_SET_BIT, 8'h16, 8'h00, 3'h1);
        `CHK(t1_fl, 8'h25)
        acc(LOWIO_OP_CLEAR_BIT, 8'h16, 8'h00, 3'h0);
        `CHK(t1_fl, 8'h25)
        acc(LOWIO_OP_IO_WRITE, 8'h16, 8'h01, 3'h0);
        `CHK(t1_fl, 8'h24)
        // Event still firing while the clear lands: the event wins
        @(posedge clk_sys_i);
        t0_evt <= 8'h07;
        acc(LOWIO_OP_IO_WRITE, 8'h15, 8'hff, 3'h0);
        `CHK(t0_fl, 8'h07)
        @(posedge clk_sys_i);
        t0_evt <= 8'h00;
        acc(LOWIO_OP_DATA_STORE, 8'h35, 8'hff, 3'h0);
        `CHK(t0_fl, 8'h00)
        $display("flag cases done");
        // Misbehaving software: reserved bits and addresses written anyway
        core_u.strict = 1'b0;
        acc(LOWIO_OP_IO_WRITE, 8'h08, 8'hff, 3'h0);
        `CHK(pc_out, 8'h7f)
        acc(LOWIO_OP_IO_WRITE, 8'h07, 8'hff, 3'h0);
        `CHK(pc_dir, 8'h7f)
        acc(LOWIO_OP_IO_WRITE, 8'h1d, 8'hff, 3'h0);
        `CHK(ei_mask, 8'h03)
        acc(LOWIO_OP_IO_WRITE, 8'h0c, 8'hff, 3'h0);
        core_u.access(LOWIO_OP_IO_READ, 8'h0c, 8'h00, 3'h0, rd, sk, er, vl);
        `CHK({rd, er}, 9'h000)
        core_u.strict = 1'b1;
        $display("reserved cases done");
        // Second reset in mid-run clears stored state
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        `CHK({pb_out, pc_out, t1_fl, ei_mask}, 32'h00000000)
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        core_u.access(LOWIO_OP_IO_READ, 8'h05, 8'h00, 3'h0, rd, sk, er, vl);
        `CHK({vl, rd, er}, 10'h200)
        $display("reset case done");
        end_of_test();
    end
endmodule : test_low_io_register_space
